// [inc/tmc_pkg.sv]
// tmc_pkg: shared types and constants for the timer/counter block.
// assumes a single core clock; every user of it writes tmc_pkg::name.
`default_nettype none
package tmc_pkg;

  // operating modes, two select bits (high, low)
  typedef enum logic [1:0] {
    TMC_MODE_13     = 2'b00,
    TMC_MODE_16     = 2'b01,
    TMC_MODE_RELOAD = 2'b10,
    TMC_MODE_SPLIT  = 2'b11
  } tmc_mode_t;

  // per-timer control bits, as software would hold them in its registers
  typedef struct packed {
    logic run_enable;     // run enable from the control register
    logic counter_sel;    // 1: count event pin, 0: count internal tick
    logic gate;           // 1: count only while the gate pin is high
    logic divide_select;  // 1: tick = clock / 4, 0: tick = clock / 12
    tmc_mode_t mode;      // mode_select_high, mode_select_low
  } tmc_cfg_t;

  // byte write strobes for one timer's count
  typedef struct packed {
    logic wr_low;         // load low byte this cycle
    logic wr_high;        // load high byte this cycle
    logic [7:0] data;     // value to load
  } tmc_wr_t;

  localparam int unsigned TMC_NUM_TIMERS = 3;
  localparam int unsigned TMC_DIV_FAST = 4;
  localparam int unsigned TMC_DIV_SLOW = 12;
  localparam logic [1:0] TMC_PRE4_LAST = 2'(TMC_DIV_FAST - 1);
  localparam logic [3:0] TMC_PRE12_LAST = 4'(TMC_DIV_SLOW - 1);
  localparam logic [7:0] TMC_BYTE_MAX = 8'hff;
  localparam logic [4:0] TMC_LOW5_MAX = 5'h1f;
  localparam logic [7:0] TMC_COUNT_RESET = 8'h00;

  // bit positions of the synchronised pin vector
  localparam int unsigned TMC_PIN_EV0 = 0;
  localparam int unsigned TMC_PIN_EV1 = 1;
  localparam int unsigned TMC_PIN_EV2 = 2;
  localparam int unsigned TMC_PIN_GATE0 = 3;
  localparam int unsigned TMC_PIN_GATE1 = 4;
  localparam int unsigned TMC_NUM_PINS = 5;

endpackage
`default_nettype wire

// [rtl/tmc_counter.sv]
// tmc_counter: one 16-bit count held as two bytes, with the four modes.
// assumes increments are already qualified by run, gate and source.
`timescale 1ns/10ps
`default_nettype none
module tmc_counter (
  input wire logic clk_sys,                  // core clock
  input wire logic rst_n,                    // synchronous reset, low
  input wire tmc_pkg::tmc_mode_t mode,       // counting mode
  input wire logic inc_low,                  // count one on low part
  input wire logic inc_high,                 // count high byte, split mode only
  input wire tmc_pkg::tmc_wr_t wr,           // software byte loads
  output logic [7:0] count_low,              // low byte register
  output logic [7:0] count_high,             // high byte register
  output logic ovf_low,                      // wrap of main count, this cycle
  output logic ovf_high                      // wrap of high byte in split mode
);
  logic [7:0] low_r, low_nxt, high_r, high_nxt;

  // next count per mode; software loads win over counting
  always_comb begin
    low_nxt = low_r;
    high_nxt = high_r;
    ovf_low = 1'b0;
    ovf_high = 1'b0;
    unique case (mode)
      tmc_pkg::TMC_MODE_13: begin
        // upper three low bits are left alone, software masks them
        if (inc_low) begin
          if (low_r[4:0] == tmc_pkg::TMC_LOW5_MAX) begin
            low_nxt[4:0] = 5'h00;
            high_nxt = high_r + 8'h01;
            ovf_low = (high_r == tmc_pkg::TMC_BYTE_MAX);
          end else begin
            low_nxt[4:0] = low_r[4:0] + 5'h01;
          end
        end
      end
      tmc_pkg::TMC_MODE_16: begin
        if (inc_low) begin
          {high_nxt, low_nxt} = {high_r, low_r} + 16'h0001;
          ovf_low = ({high_r, low_r} == 16'hffff);
        end
      end
      tmc_pkg::TMC_MODE_RELOAD: begin
        if (inc_low) begin
          if (low_r == tmc_pkg::TMC_BYTE_MAX) begin
            low_nxt = high_r;
            ovf_low = 1'b1;
          end else begin
            low_nxt = low_r + 8'h01;
          end
        end
      end
      tmc_pkg::TMC_MODE_SPLIT: begin
        // two independent 8-bit counters
        if (inc_low) begin
          low_nxt = low_r + 8'h01;
          ovf_low = (low_r == tmc_pkg::TMC_BYTE_MAX);
        end
        if (inc_high) begin
          high_nxt = high_r + 8'h01;
          ovf_high = (high_r == tmc_pkg::TMC_BYTE_MAX);
        end
      end
    endcase
    if (wr.wr_low) begin
      low_nxt = wr.data;
    end
    if (wr.wr_high) begin
      high_nxt = wr.data;
    end
  end

  // count bytes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      low_r <= tmc_pkg::TMC_COUNT_RESET;
      high_r <= tmc_pkg::TMC_COUNT_RESET;
    end else begin
      low_r <= low_nxt;
      high_r <= high_nxt;
    end
  end

  assign count_low = low_r;
  assign count_high = high_r;
endmodule
`default_nettype wire

// [rtl/tmc_top.sv]
// tmc_top: three timer/counters with prescaler, pin sync, flags, pulses.
// assumes control bits come from registers on clk_sys; pins are async.
//
// Function
// - three independent timers, each with own event pin and overflow output
// - each timer counts core-clock ticks or falling transitions on its event pin
// - 16-bit count, read and written as separate low and high bytes
// - timers 0 and 1 overflow pulse exactly one clock
// - timer 2 overflow pulses one clock; no output enable, no down count
// - modes: 13-bit, 16-bit, 8-bit reload, split (timer 0 only); timer 2 runs 16-bit only
// - mode 0 uses low five bits of low byte plus whole high byte
// - counting only while run enable set; count holds otherwise, save timer 0 high byte in split mode (timer 1 run bit)
// - counter select picks internal tick or external event pin
// - with gate set, timers 0 and 1 count only while matching interrupt pin high
// - mode 0 wraps past 1fff, sets flag, pulses output one cycle
// - mode 1 wraps from ffff, otherwise like mode 0
// - mode bits: 00 13-bit, 01 16-bit, 10 reload, 11 fourth mode
// - internal tick is clock divided by 4 or 12, per-timer select
// - overflow flag clears when processor vectors to timer interrupt
`timescale 1ns/10ps
`default_nettype none
module tmc_top (
  input wire logic clk_sys,                    // core clock
  input wire logic rst_n,                      // synchronous reset, low
  input wire logic timer0_event_input,         // async event pin, timer 0
  input wire logic timer1_event_input,         // async event pin, timer 1
  input wire logic timer2_event_input,         // async event pin, timer 2
  input wire logic ext_irq0_pin_n,             // async gate pin, timer 0
  input wire logic ext_irq1_pin_n,             // async gate pin, timer 1
  input wire tmc_pkg::tmc_cfg_t cfg0,          // timer 0 control bits
  input wire tmc_pkg::tmc_cfg_t cfg1,          // timer 1 control bits
  input wire tmc_pkg::tmc_cfg_t cfg2,          // timer 2 control (gate, mode unused)
  input wire tmc_pkg::tmc_wr_t wr0,            // timer 0 byte loads
  input wire tmc_pkg::tmc_wr_t wr1,            // timer 1 byte loads
  input wire tmc_pkg::tmc_wr_t wr2,            // timer 2 byte loads
  input wire logic [2:0] vector_ack,           // pulse: cpu vectors to timer n isr
  output logic [7:0] timer0_count_low,         // timer 0 low byte
  output logic [7:0] timer0_count_high,        // timer 0 high byte
  output logic [7:0] timer1_count_low,         // timer 1 low byte
  output logic [7:0] timer1_count_high,        // timer 1 high byte
  output logic [7:0] timer2_count_low,         // timer 2 low byte
  output logic [7:0] timer2_count_high,        // timer 2 high byte
  output logic timer0_overflow_flag,           // sticky overflow, timer 0
  output logic timer1_overflow_flag,           // sticky overflow, timer 1
  output logic timer2_overflow_flag,           // sticky overflow, timer 2
  output logic timer0_overflow_pulse,          // one-clock overflow, timer 0
  output logic timer1_overflow_pulse,          // one-clock overflow, timer 1
  output logic timer2_overflow_pulse           // one-clock overflow, timer 2
);
  localparam int unsigned NP = tmc_pkg::TMC_NUM_PINS;
  localparam int unsigned NT = tmc_pkg::TMC_NUM_TIMERS;

  logic [NP-1:0] pin_raw;
  logic [NP-1:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
  logic [NT-1:0] ev_prev_r, ev_prev_nxt, ev_fall;
  logic [1:0] pre4_r, pre4_nxt;
  logic [3:0] pre12_r, pre12_nxt;
  logic tick4, tick12;
  logic [NT-1:0] int_tick, src_tick;
  logic gate_open0, gate_open1;
  logic inc0_low, inc0_high, inc1_low, inc2_low;
  logic ovf0_low, ovf0_high, ovf1_low, ovf2_low, unused_ovf1_high, unused_ovf2_high;
  logic [NT-1:0] flag_r, flag_nxt, pulse_r, pulse_nxt;
  tmc_pkg::tmc_mode_t mode1_eff;

  assign pin_raw = {ext_irq1_pin_n, ext_irq0_pin_n, timer2_event_input,
                    timer1_event_input, timer0_event_input};

  // two-flop sync; stage one feeds only stage two to keep metastability contained
  always_comb begin
    sync1_nxt = pin_raw;
    sync2_nxt = sync1_r;
    ev_prev_nxt = sync2_r[NT-1:0];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      ev_prev_r <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      ev_prev_r <= ev_prev_nxt;
    end
  end

  // one event per falling transition on a synchronised pin
  assign ev_fall = ev_prev_r & ~sync2_r[NT-1:0];

  // free-running prescalers shared by all timers
  always_comb begin
    pre4_nxt = (pre4_r == tmc_pkg::TMC_PRE4_LAST) ? 2'h0 : pre4_r + 2'h1;
    pre12_nxt = (pre12_r == tmc_pkg::TMC_PRE12_LAST) ? 4'h0 : pre12_r + 4'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre4_r <= 2'h0;
      pre12_r <= 4'h0;
    end else begin
      pre4_r <= pre4_nxt;
      pre12_r <= pre12_nxt;
    end
  end

  assign tick4 = (pre4_r == tmc_pkg::TMC_PRE4_LAST);
  assign tick12 = (pre12_r == tmc_pkg::TMC_PRE12_LAST);

  // internal tick per divide select, then source per counter select
  always_comb begin
    int_tick[0] = cfg0.divide_select ? tick4 : tick12;
    int_tick[1] = cfg1.divide_select ? tick4 : tick12;
    int_tick[2] = cfg2.divide_select ? tick4 : tick12;
    src_tick[0] = cfg0.counter_sel ? ev_fall[0] : int_tick[0];
    src_tick[1] = cfg1.counter_sel ? ev_fall[1] : int_tick[1];
    src_tick[2] = cfg2.counter_sel ? ev_fall[2] : int_tick[2];
  end

  // gating: pin high opens the gate when gate bit set
  assign gate_open0 = ~cfg0.gate | sync2_r[tmc_pkg::TMC_PIN_GATE0];
  assign gate_open1 = ~cfg1.gate | sync2_r[tmc_pkg::TMC_PIN_GATE1];

  // increments held off unless running
  always_comb begin
    inc0_low = cfg0.run_enable & gate_open0 & src_tick[0];
    // split mode lends timer 1's run bit to timer 0's high byte
    inc0_high = cfg1.run_enable & int_tick[0];
    // timer 1 in the fourth mode just stops
    inc1_low = cfg1.run_enable & gate_open1 & src_tick[1]
               & (cfg1.mode != tmc_pkg::TMC_MODE_SPLIT);
    inc2_low = cfg2.run_enable & src_tick[2];
  end

  // timer 1 mode passed as 16-bit in the fourth mode, so split logic never runs there
  assign mode1_eff = (cfg1.mode == tmc_pkg::TMC_MODE_SPLIT) ? tmc_pkg::TMC_MODE_16 : cfg1.mode;

  // timer 0: all four modes
  tmc_counter u_timer0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mode(cfg0.mode),
    .inc_low(inc0_low),
    .inc_high(inc0_high),
    .wr(wr0),
    .count_low(timer0_count_low),
    .count_high(timer0_count_high),
    .ovf_low(ovf0_low),
    .ovf_high(ovf0_high)
  );

  // timer 1: modes 0 to 2, fourth mode stopped
  tmc_counter u_timer1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mode(mode1_eff),
    .inc_low(inc1_low),
    .inc_high(1'b0),
    .wr(wr1),
    .count_low(timer1_count_low),
    .count_high(timer1_count_high),
    .ovf_low(ovf1_low),
    .ovf_high(unused_ovf1_high)
  );

  // timer 2: plain 16-bit up count, no down count or output enable
  tmc_counter u_timer2 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mode(tmc_pkg::TMC_MODE_16),
    .inc_low(inc2_low),
    .inc_high(1'b0),
    .wr(wr2),
    .count_low(timer2_count_low),
    .count_high(timer2_count_high),
    .ovf_low(ovf2_low),
    .ovf_high(unused_ovf2_high)
  );

  // flags: set beats the vector clear so a wrap in the ack cycle is kept
  always_comb begin
    flag_nxt[0] = ovf0_low | (flag_r[0] & ~vector_ack[0]);
    flag_nxt[1] = ovf1_low | ovf0_high | (flag_r[1] & ~vector_ack[1]);
    flag_nxt[2] = ovf2_low | (flag_r[2] & ~vector_ack[2]);
    pulse_nxt[0] = ovf0_low;
    pulse_nxt[1] = ovf1_low | ovf0_high;
    pulse_nxt[2] = ovf2_low;
  end

  // flag and pulse registers, one per timer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_r <= '0;
      pulse_r <= '0;
    end else begin
      flag_r <= flag_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign timer0_overflow_flag = flag_r[0];
  assign timer1_overflow_flag = flag_r[1];
  assign timer2_overflow_flag = flag_r[2];
  assign timer0_overflow_pulse = pulse_r[0];
  assign timer1_overflow_pulse = pulse_r[1];
  assign timer2_overflow_pulse = pulse_r[2];
endmodule
`default_nettype wire

// [testbench/tmc_monitor.sv]
// tmc_monitor: port-level checks of the timer block.
// assumes one clock, rst_n synchronous and active low.
`timescale 1ns/10ps
`default_nettype none
module tmc_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire tmc_pkg::tmc_cfg_t cfg0,
  input wire tmc_pkg::tmc_wr_t wr0,
  input wire tmc_pkg::tmc_wr_t wr2,
  input wire logic [2:0] vector_ack,
  input wire logic [7:0] timer0_count_low,
  input wire logic [7:0] timer0_count_high,
  input wire logic [7:0] timer2_count_low,
  input wire logic [7:0] timer2_count_high,
  input wire logic timer0_overflow_flag,
  input wire logic timer0_overflow_pulse,
  input wire logic timer1_overflow_pulse,
  input wire logic timer2_overflow_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // timer 0 sitting at its top value
  sequence s_top13;
    cfg0.mode == tmc_pkg::TMC_MODE_13 && timer0_count_high == 8'hff && timer0_count_low[4:0] == 5'h1f;
  endsequence
  sequence s_top16;
    cfg0.mode == tmc_pkg::TMC_MODE_16 && {timer0_count_high, timer0_count_low} == 16'hffff;
  endsequence
  // undefined upper low-byte bits are masked off before the count is judged
  property p_wrap13;
    s_top13 ##1 timer0_overflow_pulse |-> {timer0_count_high, timer0_count_low[4:0]} == 13'h0 && timer0_overflow_flag;
  endproperty
  property p_wrap16;
    s_top16 ##1 timer0_overflow_pulse |-> {timer0_count_high, timer0_count_low} == 16'h0 && timer0_overflow_flag;
  endproperty
  property p_pulse0;
    timer0_overflow_pulse |=> !timer0_overflow_pulse;
  endproperty
  property p_pulse1;
    timer1_overflow_pulse |=> !timer1_overflow_pulse;
  endproperty
  property p_wrap2;
    timer2_overflow_pulse |-> {timer2_count_high, timer2_count_low} == 16'h0 &&
      $past({timer2_count_high, timer2_count_low}) == 16'hffff;
  endproperty
  // a stopped timer without loads must not move
  property p_hold;
    !cfg0.run_enable && cfg0.mode != tmc_pkg::TMC_MODE_SPLIT && !wr0.wr_low && !wr0.wr_high |=>
      $stable(timer0_count_low) && $stable(timer0_count_high);
  endproperty
  property p_wr_low;
    wr0.wr_low |=> timer0_count_low == $past(wr0.data);
  endproperty
  property p_wr_high2;
    wr2.wr_high |=> timer2_count_high == $past(wr2.data);
  endproperty
  // set wins over a clear in the same cycle
  property p_ack;
    vector_ack[0] |=> !timer0_overflow_flag || timer0_overflow_pulse;
  endproperty
  a_wrap13: assert property (p_wrap13) else $error("mode 0 wrap wrong");
  a_wrap16: assert property (p_wrap16) else $error("mode 1 wrap wrong");
  a_pulse0: assert property (p_pulse0) else $error("pulse 0 too long");
  a_pulse1: assert property (p_pulse1) else $error("pulse 1 too long");
  a_wrap2: assert property (p_wrap2) else $error("timer 2 wrap wrong");
  a_hold: assert property (p_hold) else $error("stopped count moved");
  a_wr_low: assert property (p_wr_low) else $error("low load lost");
  a_wr_high2: assert property (p_wr_high2) else $error("high load lost");
  a_ack: assert property (p_ack) else $error("flag not cleared");
endmodule
bind tmc_top tmc_monitor i_mon (.*);
`default_nettype wire

// [testbench/tmc_pins_model.sv]
// tmc_pins_model: far side driving event and gate pins.
// assumes callers step on clk_sys; pins idle high.
`timescale 1ns/10ps
`default_nettype none
module tmc_pins_model (
  input wire logic clk_sys, // core clock
  output logic [2:0] ev, // event pins
  output logic [1:0] gate_n // gate pins
);
  // idle high, so reset release shows no falling edge
  initial begin
    ev = 3'h7;
    gate_n = 2'h3;
  end
  // every level held hold cycles, two at least
  task automatic burst(input int idx, input int n, input int hold);
    repeat (n) begin
      @(posedge clk_sys);
      #1 ev[idx] = 1'b0;
      repeat (hold) @(posedge clk_sys);
      #1 ev[idx] = 1'b1;
      repeat (hold - 1) @(posedge clk_sys);
    end
  endtask
  // counting is let through only while the pin is held high
  task automatic gate(input logic [1:0] lvl);
    @(posedge clk_sys);
    #1 gate_n = lvl;
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// tb: drives the timer block, runs a cycle model beside it.
// assumes the checker is bound in and the pin model sits alongside.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic clk_sys, rst_n, cmp_on, inc, wrap, tk, hw;
  logic [2:0] vack, df, dp;
  wire logic [2:0] ev;
  wire logic [1:0] gate_n;
  tmc_pkg::tmc_cfg_t cfg [3];
  tmc_pkg::tmc_wr_t wr [3];
  tmc_pkg::tmc_mode_t md, mi;
  logic [7:0] dl [3], dh [3];
  logic [31:0] seed;
  int err_total, checks_done, k, v, n;
  int ml [3], mh [3];
  logic mf [3], mp [3];

  tmc_top i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .vector_ack(vack),
    .timer0_event_input(ev[0]), .timer1_event_input(ev[1]), .timer2_event_input(ev[2]),
    .ext_irq0_pin_n(gate_n[0]), .ext_irq1_pin_n(gate_n[1]),
    .cfg0(cfg[0]), .cfg1(cfg[1]), .cfg2(cfg[2]), .wr0(wr[0]), .wr1(wr[1]), .wr2(wr[2]),
    .timer0_count_low(dl[0]), .timer0_count_high(dh[0]), .timer1_count_low(dl[1]),
    .timer1_count_high(dh[1]), .timer2_count_low(dl[2]), .timer2_count_high(dh[2]),
    .timer0_overflow_flag(df[0]), .timer1_overflow_flag(df[1]), .timer2_overflow_flag(df[2]),
    .timer0_overflow_pulse(dp[0]), .timer1_overflow_pulse(dp[1]), .timer2_overflow_pulse(dp[2])
  );
  tmc_pins_model i_pins (.clk_sys(clk_sys), .ev(ev), .gate_n(gate_n));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // random acks each cycle keep the flags churning
  task automatic cyc(input int m);
    repeat (m) begin
      @(posedge clk_sys);
      #1 seed = xs(seed);
      vack = (seed[2:0] == 3'h0) ? seed[5:3] : 3'h0;
    end
  endtask
  task automatic load(input int i, input logic [15:0] val);
    wr[i] = {1'b1, 1'b0, val[7:0]};
    cyc(1);
    wr[i] = {1'b0, 1'b1, val[15:8]};
    cyc(1);
    wr[i] = '0;
  endtask
  // b holds run, source, gate, divide
  task automatic setall(input logic [3:0] b);
    for (int i = 0; i < 3; i++) cfg[i] = {b, md};
  endtask
  task automatic stop_test();
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  // reference model, one step per edge; loads only come while stopped
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      k = 0;
      for (int i = 0; i < 3; i++) begin
        ml[i] = 0; mh[i] = 0; mf[i] = 0; mp[i] = 0;
      end
    end else begin
      k++;
      hw = 0;
      for (int i = 0; i < 3; i++) begin
        // timer 2 is always 16-bit; timer 1 halts in the split mode
        mi = (i == 2) ? tmc_pkg::TMC_MODE_16 : cfg[i].mode;
        tk = cfg[i].divide_select ? k % 4 == 0 : k % 12 == 0;
        inc = cfg[i].run_enable && !cfg[i].counter_sel && tk;
        inc = inc && (i == 2 || !cfg[i].gate || gate_n[i % 2]);
        inc = inc && !(i == 1 && mi == tmc_pkg::TMC_MODE_SPLIT);
        wrap = 0;
        // split mode: timer 0 high byte runs on timer 0's tick and timer 1's run bit
        if (i == 0 && mi == tmc_pkg::TMC_MODE_SPLIT && cfg[1].run_enable && tk) begin
          hw = (mh[0] == 255);
          mh[0] = (mh[0] + 1) % 256;
        end
        if (wr[i].wr_low || wr[i].wr_high) begin
          if (wr[i].wr_low) ml[i] = wr[i].data;
          if (wr[i].wr_high) mh[i] = wr[i].data;
        end else if (inc && mi == tmc_pkg::TMC_MODE_13) begin
          v = mh[i] * 32 + ml[i] % 32 + 1;
          wrap = (v == 8192);
          ml[i] = ml[i] - ml[i] % 32 + v % 32;
          mh[i] = v / 32 % 256;
        end else if (inc && mi == tmc_pkg::TMC_MODE_RELOAD) begin
          wrap = (ml[i] == 255);
          ml[i] = wrap ? mh[i] : ml[i] + 1;
        end else if (inc && mi == tmc_pkg::TMC_MODE_SPLIT) begin
          wrap = (ml[i] == 255);
          ml[i] = (ml[i] + 1) % 256;
        end else if (inc) begin
          v = mh[i] * 256 + ml[i] + 1;
          wrap = (v == 65536);
          ml[i] = v % 256;
          mh[i] = v / 256 % 256;
        end
        wrap = wrap || (i == 1 && hw);
        mp[i] = wrap;
        mf[i] = wrap || (mf[i] && !vack[i]);
      end
    end
  end
  always @(negedge clk_sys) begin
    if (cmp_on && rst_n) begin
      for (int i = 0; i < 3; i++) begin
        `CHK(dl[i], 8'(ml[i]))
        `CHK(dh[i], 8'(mh[i]))
        `CHK(df[i], mf[i])
        `CHK(dp[i], mp[i])
      end
    end
  end

  initial begin
    rst_n = 0; cmp_on = 0; vack = 0; seed = 32'hf2fa;
    err_total = 0; checks_done = 0; md = tmc_pkg::TMC_MODE_13;
    setall(4'h0);
    for (int i = 0; i < 3; i++) wr[i] = '0;
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1;
    cmp_on = 1;
    // wraps in all four modes and both dividers
    for (int j = 0; j < 8; j++) begin
      md = tmc_pkg::tmc_mode_t'(j[1:0]);
      setall({3'h0, j[2]});
      cyc(5);
      for (int i = 0; i < 3; i++) begin
        seed = xs(seed);
        load(i, {8'hff, 8'hf0 | seed[7:0]});
      end
      setall({3'h4, j[2]});
      cyc(210);
    end
    // timer 1 must run below, so leave the split mode
    md = tmc_pkg::TMC_MODE_16;
    // gate pins closed then open, moved only while stopped
    for (int g = 0; g < 2; g++) begin
      setall(4'h0);
      i_pins.gate({g[0], g[0]});
      cyc(6);
      setall(4'b1011);
      cyc(60);
    end
    // event pins, one count per falling edge
    setall(4'h0);
    for (int i = 0; i < 3; i++) load(i, 16'h0000);
    cmp_on = 0;
    setall(4'b1100);
    vack = 3'h0;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      n = 1 + seed[2:0];
      i_pins.burst(i, n, 2 + seed[4:3]);
      ml[i] += n;
    end
    cyc(8);
    cmp_on = 1;
    cyc(4);
    stop_test();
  end
  // about 2000 cycles expected; cut off far beyond
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
